// *** logic/rtc_ctrl_pkg.sv ***
// Constants shared by the real-time clock control block
package rtc_ctrl_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_ALARM = 8'h08;
    localparam logic [7:0] ADDR_CAPTURE = 8'h0c;
    localparam logic [7:0] ADDR_TIMER = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int BIT_OSC_ENABLE = 7;
    localparam int BIT_MCD_ENABLE = 6;
    localparam int BIT_OSC_FAIL = 5;
    localparam int BIT_TIMER_RUN = 4;
    localparam int BIT_ALARM_ENABLE = 3;
    localparam int BIT_ALARM_FLAG = 2;
    localparam int BIT_LOAD_REQ = 1;
    localparam int BIT_SNAP_REQ = 0;
    // ------------------------------------------------------------
    // Interrupt status bits
    // ------------------------------------------------------------
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_OSC_FAIL = 1;
    localparam int IRQ_WIDTH = 2;
    // ------------------------------------------------------------
    // Timing: missing-clock timeout, 100 us at 200 MHz
    // ------------------------------------------------------------
    localparam int MISSING_CLOCK_NS = 100000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int MISSING_CLOCK_CYCLES = MISSING_CLOCK_NS / CLK_PERIOD_NS;
    localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage

// *** logic/rtc_control_register.sv ***
// Real-time clock control register, 32-bit timer and alarm with APB slave
//
// Contract
// - Control bit 7 turns low-frequency oscillator on; resets off.
// - Control bit 6 enables missing-clock detector; resets off.
// - Detector timeout sets fail flag bit 5; software writes 0 to clear.
// - Bit 4 runs timer; zero holds its value; resets off.
// - Bit 3 enables alarm generation; resets off.
// - Reading bit 2 returns the alarm event flag.
// - Writing bit 2 sets auto-reset selection, not the flag.
// - Running timer increments once per oscillator cycle.
// - Alarm event raised when timer equals alarm match value.
// - Auto-reset zeroes timer one cycle after alarm deasserts.
// - Clearing alarm enable also clears the alarm flag.
`timescale 1ns/100ps
`default_nettype none

module rtc_control_register #(
    parameter int TIMEOUT_CYCLES = rtc_ctrl_pkg::MISSING_CLOCK_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Low-frequency oscillator
    input wire logic osc_clk_in,
    output logic osc_enable_out,
    // Alarm and interrupt
    output logic alarm_event_out,
    output logic irq_out
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic osc_enable;
        logic mcd_enable;
        logic osc_fail;
        logic timer_run;
        logic alarm_enable;
        logic alarm_flag;
        logic autoreset;
        logic load_req;
        logic snap_req;
        logic [31:0] timer;
        logic [31:0] alarm_match;
        logic [31:0] capture;
        logic osc_q;
        logic [31:0] idle_cnt;
        logic pend_zero;
        logic [rtc_ctrl_pkg::IRQ_WIDTH-1:0] irq_status;
        logic [rtc_ctrl_pkg::IRQ_WIDTH-1:0] irq_mask;
        logic irq;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } state_t;

    state_t q;
    state_t next_q;

    if (TIMEOUT_CYCLES < 2) begin : g_timeout_check
        $error("TIMEOUT_CYCLES must be at least 2");
    end

    function automatic logic known_addr(input logic [7:0] a);
        return a == rtc_ctrl_pkg::ADDR_CONTROL || a == rtc_ctrl_pkg::ADDR_ALARM
            || a == rtc_ctrl_pkg::ADDR_CAPTURE || a == rtc_ctrl_pkg::ADDR_TIMER
            || a == rtc_ctrl_pkg::ADDR_IRQ_STATUS
            || a == rtc_ctrl_pkg::ADDR_IRQ_MASK;
    endfunction

    logic osc_tick;
    logic access;
    logic wr;
    logic rd;
    logic match;
    logic [7:0] ctrl_rd;
    logic mcd_fire;
    logic ctl_wr;

    assign osc_tick = q.osc_enable && osc_clk_in && !q.osc_q;
    assign access = psel_in && penable_in && !q.ready;
    assign wr = access && pwrite_in;
    assign rd = access && !pwrite_in;
    assign match = q.alarm_enable && q.timer == q.alarm_match;
    assign mcd_fire = q.mcd_enable && q.idle_cnt == 32'(TIMEOUT_CYCLES - 1);
    assign ctl_wr = wr && paddr_in == rtc_ctrl_pkg::ADDR_CONTROL;

    always_comb begin
        ctrl_rd = rtc_ctrl_pkg::RESET_BYTE;
        ctrl_rd[rtc_ctrl_pkg::BIT_OSC_ENABLE] = q.osc_enable;
        ctrl_rd[rtc_ctrl_pkg::BIT_MCD_ENABLE] = q.mcd_enable;
        ctrl_rd[rtc_ctrl_pkg::BIT_OSC_FAIL] = q.osc_fail;
        ctrl_rd[rtc_ctrl_pkg::BIT_TIMER_RUN] = q.timer_run;
        ctrl_rd[rtc_ctrl_pkg::BIT_ALARM_ENABLE] = q.alarm_enable;
        ctrl_rd[rtc_ctrl_pkg::BIT_ALARM_FLAG] = q.alarm_flag;
        ctrl_rd[rtc_ctrl_pkg::BIT_LOAD_REQ] = q.load_req;
        ctrl_rd[rtc_ctrl_pkg::BIT_SNAP_REQ] = q.snap_req;
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_q = q;
        next_q.ready = access;
        next_q.slverr = access && !known_addr(paddr_in);
        next_q.osc_q = osc_clk_in;
        // Missing-clock detector: no oscillator edge for the timeout
        if (!q.mcd_enable || osc_clk_in != q.osc_q) begin
            next_q.idle_cnt = '0;
        end else if (q.idle_cnt < 32'(TIMEOUT_CYCLES)) begin
            next_q.idle_cnt = q.idle_cnt + 32'h1;
        end
        // Timer runs on oscillator ticks; the flag stands while it matches
        next_q.alarm_flag = match;
        if (osc_tick) begin
            if (q.pend_zero) begin
                next_q.timer = '0;
                next_q.pend_zero = 1'b0;
            end else if (q.timer_run) begin
                next_q.timer = q.timer + 32'h1;
            end
            // Match ends on this tick, so the zero lands on the next one
            if (match && q.timer_run && q.autoreset) begin
                next_q.pend_zero = 1'b1;
            end
        end
        if (q.load_req) begin
            next_q.timer = q.capture;
            next_q.load_req = 1'b0;
        end
        if (q.snap_req) begin
            next_q.capture = q.timer;
            next_q.snap_req = 1'b0;
        end
        // Register writes
        if (wr && paddr_in == rtc_ctrl_pkg::ADDR_CONTROL) begin
            next_q.osc_enable =
                pwdata_in[rtc_ctrl_pkg::BIT_OSC_ENABLE];
            next_q.mcd_enable =
                pwdata_in[rtc_ctrl_pkg::BIT_MCD_ENABLE];
            if (!pwdata_in[rtc_ctrl_pkg::BIT_OSC_FAIL]) begin
                next_q.osc_fail = 1'b0;
            end
            next_q.timer_run =
                pwdata_in[rtc_ctrl_pkg::BIT_TIMER_RUN];
            next_q.alarm_enable = pwdata_in[rtc_ctrl_pkg::BIT_ALARM_ENABLE];
            next_q.autoreset =
                pwdata_in[rtc_ctrl_pkg::BIT_ALARM_FLAG];
            if (!pwdata_in[rtc_ctrl_pkg::BIT_ALARM_ENABLE]) begin
                next_q.alarm_flag = 1'b0;
            end
            if (pwdata_in[rtc_ctrl_pkg::BIT_LOAD_REQ]) begin
                next_q.load_req = 1'b1;
            end
            if (pwdata_in[rtc_ctrl_pkg::BIT_SNAP_REQ]) begin
                next_q.snap_req = 1'b1;
            end
        end
        if (wr && paddr_in == rtc_ctrl_pkg::ADDR_ALARM) begin
            next_q.alarm_match = pwdata_in;
        end
        if (wr && paddr_in == rtc_ctrl_pkg::ADDR_CAPTURE) begin
            next_q.capture = pwdata_in;
        end
        if (wr && paddr_in == rtc_ctrl_pkg::ADDR_IRQ_MASK) begin
            next_q.irq_mask = pwdata_in[rtc_ctrl_pkg::IRQ_WIDTH-1:0];
        end
        // Detector fire sets the fail flag, winning over a clear
        if (mcd_fire) begin
            next_q.osc_fail = 1'b1;
            next_q.irq_status[rtc_ctrl_pkg::IRQ_OSC_FAIL] = 1'b1;
        end
        // Read data, status cleared on read unless set again
        next_q.rdata = '0;
        if (rd) begin
            unique case (paddr_in)
                rtc_ctrl_pkg::ADDR_CONTROL: next_q.rdata = {24'h0, ctrl_rd};
                rtc_ctrl_pkg::ADDR_ALARM: next_q.rdata = q.alarm_match;
                rtc_ctrl_pkg::ADDR_CAPTURE: next_q.rdata = q.capture;
                rtc_ctrl_pkg::ADDR_TIMER: next_q.rdata = q.timer;
                rtc_ctrl_pkg::ADDR_IRQ_STATUS: begin
                    next_q.rdata = 32'(q.irq_status);
                    next_q.irq_status = '0;
                    if (mcd_fire) begin
                        next_q.irq_status[rtc_ctrl_pkg::IRQ_OSC_FAIL] = 1'b1;
                    end
                end
                rtc_ctrl_pkg::ADDR_IRQ_MASK: next_q.rdata = 32'(q.irq_mask);
                default: next_q.rdata = '0;
            endcase
        end
        if (next_q.alarm_flag && !q.alarm_flag) begin
            next_q.irq_status[rtc_ctrl_pkg::IRQ_ALARM] = 1'b1;
        end
        next_q.irq = |(next_q.irq_status & next_q.irq_mask);
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign prdata_out = q.rdata;
    assign pready_out = q.ready;
    assign pslverr_out = q.slverr;
    assign osc_enable_out = q.osc_enable;
    assign alarm_event_out = q.alarm_flag;
    assign irq_out = q.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_osc_follows;
        @(posedge clk_sys_in) disable iff (rst_in)
        wr && paddr_in == rtc_ctrl_pkg::ADDR_CONTROL |=>
            osc_enable_out == $past(pwdata_in[rtc_ctrl_pkg::BIT_OSC_ENABLE]);
    endproperty
    a_osc_follows: assert property (p_osc_follows)
        else $error("oscillator enable did not follow write");

    property p_mcd_off_no_fail;
        @(posedge clk_sys_in) disable iff (rst_in)
        !q.mcd_enable && !q.osc_fail ##1 !q.mcd_enable |-> !q.osc_fail;
    endproperty
    a_mcd_off_no_fail: assert property (p_mcd_off_no_fail)
        else $error("fail flag set with detector off");

    property p_fail_sticky;
        @(posedge clk_sys_in) disable iff (rst_in)
        q.osc_fail && !(wr && paddr_in == rtc_ctrl_pkg::ADDR_CONTROL)
            |=> q.osc_fail;
    endproperty
    a_fail_sticky: assert property (p_fail_sticky)
        else $error("fail flag dropped without a write");

    property p_timer_hold;
        @(posedge clk_sys_in) disable iff (rst_in)
        !q.timer_run && !q.load_req && !q.pend_zero |=>
            q.timer == $past(q.timer);
    endproperty
    a_timer_hold: assert property (p_timer_hold)
        else $error("stopped timer changed");

    property p_timer_inc;
        @(posedge clk_sys_in) disable iff (rst_in)
        osc_tick && q.timer_run && !q.load_req && !q.pend_zero |=>
            q.timer == $past(q.timer) + 32'h1;
    endproperty
    a_timer_inc: assert property (p_timer_inc)
        else $error("timer did not increment on tick");

    property p_alarm_needs_enable;
        @(posedge clk_sys_in) disable iff (rst_in)
        alarm_event_out |-> $past(q.alarm_enable);
    endproperty
    a_alarm_needs_enable: assert property (p_alarm_needs_enable)
        else $error("alarm raised while disabled");

    property p_alarm_on_match;
        @(posedge clk_sys_in) disable iff (rst_in)
        match && !wr |=> alarm_event_out;
    endproperty
    a_alarm_on_match: assert property (p_alarm_on_match)
        else $error("match did not raise alarm");

    property p_disable_clears;
        @(posedge clk_sys_in) disable iff (rst_in)
        ctl_wr && !pwdata_in[rtc_ctrl_pkg::BIT_ALARM_ENABLE]
            |=> !alarm_event_out;
    endproperty
    a_disable_clears: assert property (p_disable_clears)
        else $error("alarm flag not cleared by disable");

    property p_req_done;
        @(posedge clk_sys_in) disable iff (rst_in)
        q.snap_req |=> !q.snap_req && q.capture == $past(q.timer);
    endproperty
    a_req_done: assert property (p_req_done)
        else $error("snapshot did not complete");

    property p_load_done;
        @(posedge clk_sys_in) disable iff (rst_in)
        q.load_req && !ctl_wr |=>
            !q.load_req && q.timer == $past(q.capture);
    endproperty
    a_load_done: assert property (p_load_done)
        else $error("timer load did not complete");

    property p_autoreset_zero;
        @(posedge clk_sys_in) disable iff (rst_in)
        osc_tick && q.pend_zero && !q.load_req |=>
            q.timer == 32'h0;
    endproperty
    a_autoreset_zero: assert property (p_autoreset_zero)
        else $error("auto-reset did not zero the timer");

    property p_fail_on_timeout;
        @(posedge clk_sys_in) disable iff (rst_in)
        mcd_fire |=>
            q.osc_fail;
    endproperty
    a_fail_on_timeout: assert property (p_fail_on_timeout)
        else $error("detector timeout did not set fail flag");

    property p_autoreset_write;
        @(posedge clk_sys_in) disable iff (rst_in)
        ctl_wr |=>
            q.autoreset == $past(pwdata_in[rtc_ctrl_pkg::BIT_ALARM_FLAG]);
    endproperty
    a_autoreset_write: assert property (p_autoreset_write)
        else $error("auto-reset selection did not follow write");

    property p_flag_not_written;
        @(posedge clk_sys_in) disable iff (rst_in)
        ctl_wr && pwdata_in[rtc_ctrl_pkg::BIT_ALARM_FLAG] && !match |=>
            !alarm_event_out;
    endproperty
    a_flag_not_written: assert property (p_flag_not_written)
        else $error("write of bit 2 raised the alarm flag");

    property p_run_write;
        @(posedge clk_sys_in) disable iff (rst_in)
        ctl_wr |=>
            q.timer_run == $past(pwdata_in[rtc_ctrl_pkg::BIT_TIMER_RUN]);
    endproperty
    a_run_write: assert property (p_run_write)
        else $error("run bit did not follow write");

    property p_mcd_write;
        @(posedge clk_sys_in) disable iff (rst_in)
        ctl_wr |=>
            q.mcd_enable == $past(pwdata_in[rtc_ctrl_pkg::BIT_MCD_ENABLE]);
    endproperty
    a_mcd_write: assert property (p_mcd_write)
        else $error("detector enable did not follow write");
endmodule

`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the real-time clock control block
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTL = rtc_ctrl_pkg::ADDR_CONTROL;
    localparam logic [7:0] A_TMR = rtc_ctrl_pkg::ADDR_TIMER;
    localparam logic [7:0] A_CAP = rtc_ctrl_pkg::ADDR_CAPTURE;
    localparam logic [7:0] A_STS = rtc_ctrl_pkg::ADDR_IRQ_STATUS;
    localparam logic [7:0] A_MSK = rtc_ctrl_pkg::ADDR_IRQ_MASK;
    localparam logic [31:0] NO_FAIL = 32'hffffffdf;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic osc_clk_in = 1'b0;
    logic osc_enable_out;
    logic alarm_event_out;
    logic irq_out;
    logic [31:0] rd;
    logic err;
    int n_fail = 0;
    int n_checks = 0;

    always #2.5 clk_sys_in = ~clk_sys_in;

    rtc_control_register #(.TIMEOUT_CYCLES(16)) dut (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .psel_in(psel_in),
        .penable_in(penable_in),
        .pwrite_in(pwrite_in),
        .paddr_in(paddr_in),
        .pwdata_in(pwdata_in),
        .prdata_out(prdata_out),
        .pready_out(pready_out),
        .pslverr_out(pslverr_out),
        .osc_clk_in(osc_clk_in),
        .osc_enable_out(osc_enable_out),
        .alarm_event_out(alarm_event_out),
        .irq_out(irq_out)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] data);
        int i;
        @(posedge clk_sys_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= addr;
        pwdata_in <= data;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys_in);
            if (pready_out === 1'b1) break;
        end
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        if (i == 20) begin
            n_fail++;
            complete_run();
        end
    endtask

    task automatic rdchk(input string name, input logic [7:0] addr,
                         input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check(name, rd & mask, exp);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk_sys_in);
        #1;
    endtask

    task automatic pin(input string name, input logic seen,
                       input logic exp);
        settle();
        check(name, {31'h0, seen}, {31'h0, exp});
    endtask

    // Oscillator cycles: rising edges spaced for the input sampler
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys_in);
            osc_clk_in <= 1'b1;
            repeat (3) @(posedge clk_sys_in);
            osc_clk_in <= 1'b0;
            repeat (3) @(posedge clk_sys_in);
        end
    endtask

    task automatic poll(input logic [31:0] bits);
        int i;
        for (i = 0; i < 10; i++) begin
            apb(1'b0, A_CTL, 32'h0);
            if ((rd & bits) === 32'h0) break;
        end
        check("request bit", rd & bits, 32'h0);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        rdchk("ctl reset", A_CTL, NO_FAIL, 32'h0);
        pin("osc en reset", osc_enable_out, 1'b0);
        rdchk("unmapped", 8'h1c, 32'hffffffff, 32'h0);
        check("slverr", {31'h0, err}, 32'h1);
        apb(1'b1, A_CTL, 32'h80);
        pin("osc en", osc_enable_out, 1'b1);
        // Load, run, hold and snapshot of the timer
        apb(1'b1, A_CAP, 32'h10);
        apb(1'b1, A_CTL, 32'h82);
        poll(32'h2);
        rdchk("timer load", A_TMR, 32'hffffffff, 32'h10);
        apb(1'b1, A_CTL, 32'h90);
        tick(3);
        rdchk("timer run", A_TMR, 32'hffffffff, 32'h13);
        rdchk("ctl run", A_CTL, NO_FAIL, 32'h90);
        apb(1'b1, A_CTL, 32'h80);
        tick(2);
        rdchk("timer hold", A_TMR, 32'hffffffff, 32'h13);
        apb(1'b1, A_CTL, 32'h81);
        poll(32'h1);
        rdchk("snapshot", A_CAP, 32'hffffffff, 32'h13);
        // Alarm match, flag read, clear by disable, interrupt
        apb(1'b1, rtc_ctrl_pkg::ADDR_ALARM, 32'h15);
        rdchk("alarm rb", rtc_ctrl_pkg::ADDR_ALARM, 32'hffffffff, 32'h15);
        apb(1'b1, A_MSK, 32'h1);
        apb(1'b1, A_CTL, 32'h98);
        tick(1);
        pin("alarm early", alarm_event_out, 1'b0);
        tick(1);
        pin("alarm match", alarm_event_out, 1'b1);
        pin("irq alarm", irq_out, 1'b1);
        rdchk("ctl flag", A_CTL, NO_FAIL, 32'h9c);
        apb(1'b1, A_CTL, 32'h90);
        pin("alarm off", alarm_event_out, 1'b0);
        rdchk("ctl no flag", A_CTL, NO_FAIL, 32'h90);
        rdchk("status set", A_STS, 32'hffffffff, 32'h1);
        rdchk("status clr", A_STS, 32'hffffffff, 32'h0);
        pin("irq clr", irq_out, 1'b0);
        // Auto-reset: zero one cycle after the alarm ends
        apb(1'b1, rtc_ctrl_pkg::ADDR_ALARM, 32'h17);
        apb(1'b1, A_CTL, 32'h9c);
        rdchk("auto sel", A_CTL, NO_FAIL, 32'h98);
        tick(2);
        pin("alarm auto", alarm_event_out, 1'b1);
        tick(1);
        rdchk("timer past", A_TMR, 32'hffffffff, 32'h18);
        tick(1);
        rdchk("timer zero", A_TMR, 32'hffffffff, 32'h0);
        // Missing-clock detector, sticky flag, masking
        apb(1'b1, A_CTL, 32'h80);
        rdchk("status alarm", A_STS, 32'hffffffff, 32'h1);
        apb(1'b1, A_MSK, 32'h0);
        apb(1'b1, A_CTL, 32'hc0);
        repeat (40) @(posedge clk_sys_in);
        rdchk("fail set", A_CTL, 32'hff, 32'he0);
        pin("irq masked", irq_out, 1'b0);
        apb(1'b1, A_MSK, 32'h2);
        pin("irq fail", irq_out, 1'b1);
        tick(1);
        rdchk("fail sticky", A_CTL, 32'hff, 32'he0);
        apb(1'b1, A_CTL, 32'h80);
        rdchk("fail clr", A_CTL, 32'hff, 32'h80);
        rdchk("status fail", A_STS, 32'hffffffff, 32'h2);
        pin("irq off", irq_out, 1'b0);
        // Reset in mid-run returns every control bit to off
        @(posedge clk_sys_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        rdchk("ctl reset 2", A_CTL, NO_FAIL, 32'h0);
        rdchk("mask reset", A_MSK, 32'hffffffff, 32'h0);
        rdchk("timer reset", A_TMR, 32'hffffffff, 32'h0);
        pin("osc en off", osc_enable_out, 1'b0);
        complete_run();
    end
endmodule
`default_nettype wire
